//--- rtl/cpt_pkg.sv
// package with register map, field layout and reset constants for the pwm timer
// Overview of operation
// - center mode counts up to modulo, then down
// - period starts at modulo minus one to modulo
// - zero and modulo last one count each
// - each pin driven by reset-low hidden flop
// - output flop changes on compare match or at period start
// - outputs hold level until next compare or period start
// - counter resets to zero, mid-period start
// - channel equal modulo gives full duty
// - channel modulo minus one gives proportional duty
// - negative channel value gives zero duty
// - new center duty starts next period
// - edge mode zero-to-nonzero may lag
// - prescaler keeps count across setting change
// - three-bit prescale encodes power-of-two divide
// - channel value is 16-bit, high/low bytes
// - any counter byte write clears counter
// - clock select zero stops, else runs
package cpt_pkg;
  localparam int CPT_AW = 4;
  // word indices; byte address is four times the index
  localparam logic [CPT_AW-1:0] CPT_CTRL_IDX = 4'h0;
  localparam logic [CPT_AW-1:0] CPT_CNTH_IDX = 4'h1;
  localparam logic [CPT_AW-1:0] CPT_CNTL_IDX = 4'h2;
  localparam logic [CPT_AW-1:0] CPT_MODH_IDX = 4'h3;
  localparam logic [CPT_AW-1:0] CPT_MODL_IDX = 4'h4;
  localparam logic [CPT_AW-1:0] CPT_CH0H_IDX = 4'h5;
  localparam logic [CPT_AW-1:0] CPT_CH0L_IDX = 4'h6;
  localparam logic [CPT_AW-1:0] CPT_CH1H_IDX = 4'h7;
  localparam logic [CPT_AW-1:0] CPT_CH1L_IDX = 4'h8;
  // control register fields
  localparam int CPT_PS_LSB = 0;
  localparam int CPT_CLKS_LSB = 3;
  localparam int CPT_CPWM_BIT = 5;
  localparam logic [7:0] CPT_CTRL_RST = 8'h00;
  localparam logic [15:0] CPT_MOD_RST = 16'h0000;
  localparam logic [15:0] CPT_CNT_RST = 16'h0000;
  localparam logic [15:0] CPT_CHV_RST = 16'h0000;
  localparam logic [1:0] CPT_CLKS_OFF = 2'h0;
  localparam logic [31:0] CPT_UNMAPPED = 32'h0000_0000;
  // bus request bundle
  typedef struct packed {
    logic rd;
    logic wr;
    logic [CPT_AW-1:0] idx;
    logic [7:0] wdata;
  } cpt_req_t;
endpackage

//--- rtl/cpt_timer.sv
// center/edge aligned pwm timer with avalon-mm register slave
//
// Implementation choices: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ps
module cpt_timer
  import cpt_pkg::*;
#(
  parameter int NCH = 2
) (
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic [CPT_AW+1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  output logic [NCH-1:0] o_pwm
);
  // decoded request for this cycle
  cpt_req_t req;
  logic busy_reg; // one-cycle answer phase
  logic [7:0] ctrl_reg; // prescale, clock select, center mode
  logic [15:0] mod_reg; // modulo_value
  logic [15:0] cnt_reg; // counter_value
  logic down_reg; // direction indicator, 1 = counting down
  logic [6:0] pre_reg; // prescaler divider flops
  logic [15:0] chv_reg [NCH]; // channel_compare_value as written
  logic [15:0] act_reg [NCH]; // channel value in use
  logic [NCH-1:0] pwm_reg; // hidden output flops
  logic tick; // one-cycle count enable
  logic per_start; // a new pwm period begins
  logic cnt_clr; // software write to a counter byte

  // word index decode from the byte address
  function automatic logic [CPT_AW-1:0] idx_of(
    input logic [CPT_AW+1:0] a);
    idx_of = a[CPT_AW+1:2];
  endfunction

  // prescale divide-by mask, setting n divides by 2**n
  function automatic logic [6:0] ps_mask(input logic [2:0] ps);
    ps_mask = 7'((8'h01 << ps) - 8'h01);
  endfunction

  always_comb begin
    req.rd = i_avs_read & ~busy_reg;
    req.wr = i_avs_write & ~busy_reg & i_avs_byteenable[0];
    req.idx = idx_of(i_avs_address);
    req.wdata = i_avs_writedata[7:0];
  end

  // waitrequest stays high until the answer cycle; answer one cycle later
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      busy_reg <= 1'b0;
      o_avs_waitrequest <= 1'b1;
    end else begin
      busy_reg <= (i_avs_read | i_avs_write) & ~busy_reg;
      o_avs_waitrequest <= ~((i_avs_read | i_avs_write) & ~busy_reg);
    end
  end

  // read data mux; high byte, low byte, unmapped reads zero
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_avs_readdata <= CPT_UNMAPPED;
    end else if (req.rd) begin
      case (req.idx)
        CPT_CTRL_IDX: o_avs_readdata <= {24'h00_0000, ctrl_reg};
        CPT_CNTH_IDX: o_avs_readdata <= {24'h00_0000, cnt_reg[15:8]};
        CPT_CNTL_IDX: o_avs_readdata <= {24'h00_0000, cnt_reg[7:0]};
        CPT_MODH_IDX: o_avs_readdata <= {24'h00_0000, mod_reg[15:8]};
        CPT_MODL_IDX: o_avs_readdata <= {24'h00_0000, mod_reg[7:0]};
        CPT_CH0H_IDX: o_avs_readdata <= {24'h00_0000, chv_reg[0][15:8]};
        CPT_CH0L_IDX: o_avs_readdata <= {24'h00_0000, chv_reg[0][7:0]};
        CPT_CH1H_IDX: o_avs_readdata <= {24'h00_0000,
                                         chv_reg[NCH-1][15:8]};
        CPT_CH1L_IDX: o_avs_readdata <= {24'h00_0000,
                                         chv_reg[NCH-1][7:0]};
        default: o_avs_readdata <= CPT_UNMAPPED;
      endcase
    end
  end

  // control and modulo registers
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ctrl_reg <= CPT_CTRL_RST;
      mod_reg <= CPT_MOD_RST;
    end else if (req.wr) begin
      case (req.idx)
        CPT_CTRL_IDX: ctrl_reg <= req.wdata;
        CPT_MODH_IDX: mod_reg[15:8] <= req.wdata;
        CPT_MODL_IDX: mod_reg[7:0] <= req.wdata;
        default: ctrl_reg <= ctrl_reg;
      endcase
    end
  end

  // any write to either counter byte clears the count
  assign cnt_clr = req.wr & ((req.idx == CPT_CNTH_IDX) |
                             (req.idx == CPT_CNTL_IDX));

  // prescaler: divider count survives a setting change, so the first
  // tick after a change may come early or late
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pre_reg <= 7'h00;
    end else if (ctrl_reg[CPT_CLKS_LSB +: 2] != CPT_CLKS_OFF) begin
      pre_reg <= pre_reg + 7'h01;
    end
  end

  // tick when all low bits selected by the mask are ones
  assign tick = (ctrl_reg[CPT_CLKS_LSB +: 2] != CPT_CLKS_OFF) &&
                ((pre_reg & ps_mask(ctrl_reg[CPT_PS_LSB +: 3])) ==
                 ps_mask(ctrl_reg[CPT_PS_LSB +: 3]));

  // period start: up-to-down turn in center mode, wrap in edge mode
  assign per_start = tick & (ctrl_reg[CPT_CPWM_BIT] ?
    (!down_reg && cnt_reg == mod_reg - 16'h0001) :
    (cnt_reg == mod_reg));

  // main counter and direction; reset value zero is mid-period in
  // center mode
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt_reg <= CPT_CNT_RST;
      down_reg <= 1'b0;
    end else if (cnt_clr) begin
      cnt_reg <= CPT_CNT_RST;
      down_reg <= 1'b0;
    end else if (tick) begin
      if (!ctrl_reg[CPT_CPWM_BIT]) begin
        // edge mode: up to modulo then wrap
        down_reg <= 1'b0;
        cnt_reg <= (cnt_reg >= mod_reg) ? 16'h0000 :
                   cnt_reg + 16'h0001;
      end else if (mod_reg == 16'h0000) begin
        cnt_reg <= 16'h0000;
      end else if (!down_reg) begin
        // modulo shows for one count, then down
        if (cnt_reg >= mod_reg - 16'h0001) begin
          cnt_reg <= mod_reg;
          down_reg <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg + 16'h0001;
        end
      end else begin
        // zero shows for one count, then up
        if (cnt_reg <= 16'h0001) begin
          cnt_reg <= 16'h0000;
          down_reg <= 1'b0;
        end else begin
          cnt_reg <= cnt_reg - 16'h0001;
        end
      end
    end
  end

  // per-channel value registers, output flops and compare logic
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : gen_ch
      logic [CPT_AW-1:0] hi_idx;
      logic [15:0] act_next;
      logic neg; // negative value means zero duty
      logic hit;
      assign hi_idx = 4'(CPT_CH0H_IDX + 4'(2 * g));
      assign neg = act_reg[g][15];

      // 16-bit value, written a byte at a time
      always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
          chv_reg[g] <= CPT_CHV_RST;
        end else if (req.wr && req.idx == hi_idx) begin
          chv_reg[g][15:8] <= req.wdata;
        end else if (req.wr && req.idx == hi_idx + 4'h1) begin
          chv_reg[g][7:0] <= req.wdata;
        end
      end

      // the written value is adopted only at a period start
      assign act_next = chv_reg[g];
      always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
          act_reg[g] <= CPT_CHV_RST;
        end else if (per_start) begin
          act_reg[g] <= act_next;
        end
      end

      // compare event: value equals the count on a tick
      assign hit = tick & (act_reg[g] == cnt_reg);

      // flop only moves on compare events or at the period start, where edge
      // mode sets every rise and center mode the corners and modulo minus one; hidden from software
      always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
          pwm_reg[g] <= 1'b0;
        end else if (ctrl_reg[CPT_CPWM_BIT]) begin
          if (per_start) begin
            // next period's value decides the level at its start
            if (act_next[15]) begin
              pwm_reg[g] <= 1'b0;
            end else if (act_next >= mod_reg) begin
              pwm_reg[g] <= 1'b1;
            end else if (act_next == mod_reg - 16'h0001) begin
              pwm_reg[g] <= 1'b0; // active from next down match
            end
          end else if (hit && !neg && act_reg[g] < mod_reg) begin
            // down count match goes active, up count match inactive
            pwm_reg[g] <= down_reg;
          end
        end else begin
          if (per_start) begin
            pwm_reg[g] <= !act_next[15] && (act_next != 16'h0000);
          end else if (hit && !neg) begin
            pwm_reg[g] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  assign o_pwm = pwm_reg;
endmodule

//--- bench/cpt_timer_asserts.sv
// bus handshake and output reset checks for the pwm timer
`timescale 1ns/1ps
module cpt_timer_chk
  import cpt_pkg::*;
#(parameter int NCH = 2) (
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic [CPT_AW+1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] o_avs_readdata,
  input wire logic o_avs_waitrequest,
  input wire logic [NCH-1:0] o_pwm
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);
  // request met while the slave stalls
  sequence s_take; (i_avs_read || i_avs_write) && o_avs_waitrequest; endsequence
  // a single low cycle, then stall again
  sequence s_ans; !o_avs_waitrequest ##1 o_avs_waitrequest; endsequence
  a_bus_answer: assert property (s_take |=> s_ans) else $error("bad answer");
  a_no_spurious: assert property (!o_avs_waitrequest
    |-> $past(i_avs_read || i_avs_write)) else $error("spurious answer");
  a_idle_stall: assert property (!(i_avs_read || i_avs_write)
    && o_avs_waitrequest |=> o_avs_waitrequest) else $error("idle answer");
  a_upper_zero: assert property (o_avs_readdata[31:8] == 24'h00_0000)
    else $error("upper read bits set");
  a_unmapped_zero: assert property (s_take and i_avs_read
    && i_avs_address[CPT_AW+1:2] > CPT_CH1L_IDX
    |=> o_avs_readdata == 32'h0000_0000) else $error("unmapped data");
  a_rdata_hold: assert property ($changed(o_avs_readdata)
    |-> $past(i_avs_read && o_avs_waitrequest)) else $error("data moved");
  a_write_keep: assert property (s_take and i_avs_write
    |=> $stable(o_avs_readdata)) else $error("write moved data");
  a_pwm_reset: assert property ($rose(i_rst_b) |-> o_pwm == '0)
    else $error("pwm not low after reset");
endmodule
bind cpt_timer cpt_timer_chk #(.NCH(NCH)) u_cpt_timer_chk (.i_core_clk,
  .i_rst_b, .i_avs_address, .i_avs_read, .i_avs_write, .o_avs_readdata,
  .o_avs_waitrequest, .o_pwm);

//--- bench/cpt_load.sv
// load on one pwm pin that counts cycles at the active level
`timescale 1ns/1ps
module cpt_load (
  input wire logic i_core_clk,
  input wire logic i_pin,
  input wire logic i_clr,
  output logic [15:0] o_high_cnt
);
  // a pure sink: it samples the pin and never drives back
  always_ff @(posedge i_core_clk) begin
    if (i_clr) begin
      o_high_cnt <= 16'h0000;
    end else if (i_pin) begin
      o_high_cnt <= o_high_cnt + 16'h0001;
    end
  end
endmodule

//--- bench/tb_cpt_timer.sv
// self-checking bench for the pwm timer
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fails++; \
  $display("CHECK FAILED %0t got %h exp %h", $time, g, e); end end
module tb_cpt_timer;
  import cpt_pkg::*;
  logic clk = 0, rst_b = 0, rd = 0, we = 0, clr = 0, wait_r, ctr;
  logic [5:0] adr = 6'h00;
  logic [31:0] wd = 32'h0000_0000, rdata, q;
  logic [3:0] be = 4'hf;
  logic [1:0] pwm, p;
  logic [15:0] hi0, hi1, m, v0, v1;
  int fails = 0, checked = 0, seed = 34122, cyc = 0, ps, w;
  cpt_timer #(.NCH(2)) u_cpt_timer (.i_core_clk(clk), .i_rst_b(rst_b),
    .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(we),
    .i_avs_writedata(wd), .i_avs_byteenable(be), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wait_r), .o_pwm(pwm));
  cpt_load u_cpt_load0 (.i_core_clk(clk), .i_pin(pwm[0]), .i_clr(clr),
    .o_high_cnt(hi0));
  cpt_load u_cpt_load1 (.i_core_clk(clk), .i_pin(pwm[1]), .i_clr(clr),
    .o_high_cnt(hi1));
  initial forever #12.5 clk = ~clk;
  task automatic wrap_up();
    if (fails == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // hang guard, far above the few thousand cycles the run needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      fails++;
      wrap_up();
    end
  end
  // one transfer; values are read before this edge's updates land
  task automatic bus(input logic w_en, input logic [3:0] idx,
                     input logic [7:0] d);
    @(posedge clk);
    rd <= !w_en;
    we <= w_en;
    adr <= {idx, 2'b00};
    wd <= {24'h00_0000, d};
    do @(posedge clk); while (wait_r !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    we <= 1'b0;
  endtask
  // high byte first, low byte at the next index
  task automatic put16(input logic [3:0] idx, input logic [15:0] v);
    bus(1'b1, idx, v[15:8]);
    bus(1'b1, idx + 4'h1, v[7:0]);
  endtask
  // active cycles in one steady period
  function automatic int exp_hi(input logic [15:0] v);
    int h;
    if (v[15]) h = 0;
    else if (ctr) h = (v >= m) ? 2 * m : 2 * v;
    // edge mode: the output drops on the tick that leaves count v, so a
    // nonzero value stays high for v + 1 counts, capped at the full period
    else if (v == 16'h0000) h = 0;
    else h = (v >= m) ? m + 1 : v + 1;
    return h << ps;
  endfunction
  function automatic logic [15:0] rnd_v();
    int r;
    r = $random(seed) & 32'h0000_ffff;
    return ctr ? 16'(r % (m + 1)) : 16'(1 + r % (m - 1));
  endfunction
  // stop, clear, program, restart, settle, then measure one period
  task automatic run_case();
    w = ctr ? (2 * m) << ps : (m + 1) << ps;
    bus(1'b1, CPT_CTRL_IDX, 8'h00);
    p = pwm;
    repeat (10) @(posedge clk);
    `CHK(pwm, p)
    bus(1'b1, CPT_CNTH_IDX, 8'($random(seed)));
    bus(1'b0, CPT_CNTL_IDX, 8'h00);
    `CHK(q, 32'h0000_0000)
    put16(CPT_MODH_IDX, m);
    put16(CPT_CH0H_IDX, v0);
    put16(CPT_CH1H_IDX, v1);
    bus(1'b1, CPT_CTRL_IDX, {2'b00, ctr, 2'b01, 3'(ps)});
    repeat (2 * w) @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    repeat (w + 1) @(posedge clk);
    `CHK(hi0, 16'(exp_hi(v0)))
    `CHK(hi1, 16'(exp_hi(v1)))
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    `CHK(pwm, 2'b00)
    bus(1'b0, CPT_CNTL_IDX, 8'h00);
    `CHK(q, 32'h0000_0000)
    bus(1'b0, 4'hc, 8'h00);
    `CHK(q, 32'h0000_0000)
    be <= 4'he;
    bus(1'b1, CPT_CH0L_IDX, 8'h55);
    be <= 4'hf;
    bus(1'b0, CPT_CH0L_IDX, 8'h00);
    `CHK(q, 32'h0000_0000)
    // corners: full, full less one, negatives, divide by two, edge mode
    m = 16'h0008;
    ctr = 1'b1;
    ps = 0;
    v0 = 16'h0008;
    v1 = 16'h0007;
    run_case();
    ps = 1;
    v0 = 16'h8000;
    v1 = 16'hffff;
    run_case();
    ps = 0;
    v0 = 16'h0009;
    v1 = 16'h0006;
    run_case();
    ctr = 1'b0;
    v0 = 16'h0003;
    v1 = 16'h0000;
    run_case();
    for (int i = 0; i < 8; i++) begin
      m = 16'(4 + ($random(seed) & 32'h0000_000f));
      ctr = 1'($random(seed));
      ps = ($random(seed) & 32'h0000_0003) % 3;
      v0 = rnd_v();
      v1 = rnd_v();
      run_case();
    end
    wrap_up();
  end
endmodule
